//--- pkg/loop_comp_map.svh
// Offsets, field positions, reset values and timing counts
`ifndef LOOP_COMP_MAP_SVH
`define LOOP_COMP_MAP_SVH
`define OFS_CTRL        12'h000
`define OFS_MODE        12'h004
`define OFS_GAIN        12'h008
`define OFS_TRIG        12'h00C
`define OFS_STORE       12'h010
`define OFS_COEF_A      12'h014
`define OFS_COEF_B      12'h018
`define OFS_COEF_C      12'h01C
`define OFS_STATUS      12'h020
`define OFS_TUNE_A      12'h024
`define OFS_TUNE_B      12'h028
`define OFS_TUNE_C      12'h02C
`define CTRL_OUT_EN     0
`define CTRL_ONCE_ONLY  1
`define MODE_RST        2'h1
`define GAIN_RST        7'h32
`define GAIN_MIN        7'h0A
`define GAIN_MAX        7'h64
`define SAFE_A          16'h1000
`define SAFE_B          16'hE000
`define SAFE_C          16'h1000
`define USER_RST_A      16'h0800
`define USER_RST_B      16'hF000
`define USER_RST_C      16'h0800
`define CLK_MHZ         200
`define PERIOD_SEC_MS   1000
`define PERIOD_MIN_MS   60000
`define TUNE_MIN_MS     50
`define TUNE_MAX_MS     200
`endif

//--- pkg/loop_comp_pkg.sv
// Types shared by the loop compensation control block
package loop_comp_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_ON_ENABLE, MODE_EVERY_SEC, MODE_EVERY_MIN} tune_mode_e;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } coef_set_s;
endpackage

//--- design/coef_store.sv
// User non-volatile coefficient store with registered read
`timescale 1ns/100ps
module coef_store
  import loop_comp_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      ce,
  input  wire logic      wr,
  input  wire coef_set_s wdata,
  output coef_set_s      rdata
);
`include "loop_comp_map.svh"
  coef_set_s mem_ff;

  // Storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_ff <= '{a: `USER_RST_A, b: `USER_RST_B, c: `USER_RST_C};
    else if (ce && wr)
      mem_ff <= wdata;
  end

  // Registered read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= '{a: `USER_RST_A, b: `USER_RST_B, c: `USER_RST_C};
    else if (ce)
      rdata <= mem_ff;
  end
endmodule

//--- design/tune_engine.sv
// Tuning run timer and gain scaled result
`timescale 1ns/100ps
module tune_engine
  import loop_comp_pkg::*;
#(
  parameter int RUN_CYCLES = 10000000
)
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      ce,
  input  wire logic      start,
  input  wire logic [6:0] gain,
  input  wire coef_set_s base,
  output logic           busy,
  output logic           done,
  output coef_set_s      result
);
`include "loop_comp_map.svh"
  logic [31:0] cnt_ff;

  function automatic logic [15:0] scale(input logic [15:0] v, input logic [6:0] g);
    logic signed [31:0] p;
    p = $signed({{16{v[15]}}, v}) * $signed({25'h0, g});
    return 16'(p / 32'sd50);
  endfunction

  // Run timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy   <= 1'b0;
      done   <= 1'b0;
      cnt_ff <= 32'h0;
      result <= '0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy   <= 1'b1;
        cnt_ff <= 32'(RUN_CYCLES - 1);
      end
      else if (busy)
      begin
        if (cnt_ff == 32'h0)
        begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= '{a: scale(base.a, gain), b: scale(base.b, gain), c: scale(base.c, gain)};
        end
        else
          cnt_ff <= cnt_ff - 32'h1;
      end
    end
  end

  // ==========================================================
  // Checks
  busy_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && busy && cnt_ff != 32'h0 |=> busy && cnt_ff == $past(cnt_ff) - 32'h1)
    else $error("tuning run restarted while busy");
endmodule

//--- design/adaptive_loop_comp_ctrl.sv
// Adaptive loop compensation control with APB registers
// Overview of operation
// - Fixed-frequency voltage-mode loop uses the active coefficients from RAM.
// - Host writes coefficient set; device applies it to the loop.
// - Default mode starts tuning after ramp-up and installs the result.
// - A tuning run completes within 50 ms to 200 ms.
// - Mode selects off, on enable, every second or every minute.
// - Once-only option tunes first ramp after power, reuses result later.
// - Host trigger starts a tuning run whenever no run is busy.
// - Result scaled by gain/50: 20% to 200%, default 100%.
// - Loop always uses RAM, filled at power-up from safe default set or user store.
// - Tuning enabled at power-up loads fixed safe default set.
// - Finished tuning run writes its set into RAM when tuning is on.
// - Store saves the active RAM set, default or tuned.
// - Tuning off to on loads the safe default set.
// - Tuning on to off reloads the user-stored set.
// - Tuning disabled at power-up loads the user-stored set.
`timescale 1ns/100ps
`include "loop_comp_map.svh"
module adaptive_loop_comp_ctrl
  import loop_comp_pkg::*;
#(
  parameter int RUN_CYCLES = (`TUNE_MIN_MS + `TUNE_MAX_MS) / 2 * 1000 * `CLK_MHZ,
  parameter int SEC_CYCLES = `PERIOD_SEC_MS * 1000 * `CLK_MHZ,
  parameter int MIN_CYCLES = 60 * 1000
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        ramp_done,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output coef_set_s        loop_coef,
  output logic             tune_busy
);

  // ==========================================================
  // State
  typedef enum logic [1:0] {INIT_READ, INIT_LOAD, RUNNING} init_e;
  init_e       init_ff;
  coef_set_s   ram_ff;
  tune_mode_e  mode_ff;
  logic [6:0]  gain_ff;
  logic        out_en_ff;
  logic        once_ff;
  logic        tuned_once_ff;
  logic [2:0]  ramp_sync_ff;
  logic        ramp_d_ff;
  logic        store_wr_ff;
  logic [35:0] per_cnt_ff;
  logic        trig_ff;
  coef_set_s   user_rd;
  coef_set_s   tune_res;
  logic        tune_done;
  logic        eng_busy;
  logic        acc;
  logic        wr_acc;
  logic        mapped;
  logic        ramp_rise;
  logic        tune_on;
  logic        per_hit;
  logic        req;
  tune_mode_e  nxt_mode;

  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite && ce;
  assign tune_on = (mode_ff != MODE_OFF);
  assign nxt_mode = tune_mode_e'(pwdata[1:0]);

  // ==========================================================
  // Ramp-done pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_sync_ff <= 3'h0;
      ramp_d_ff    <= 1'b0;
    end
    else if (ce)
    begin
      ramp_sync_ff <= {ramp_sync_ff[1:0], ramp_done};
      if (ramp_sync_ff[1] == ramp_sync_ff[2])
        ramp_d_ff <= ramp_sync_ff[2];
    end
  end

  logic ramp_prev_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_prev_ff <= 1'b0;
    else if (ce)
      ramp_prev_ff <= ramp_d_ff;
  end
  assign ramp_rise = ramp_d_ff && !ramp_prev_ff && out_en_ff;

  // ==========================================================
  // Periodic tuning timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      per_cnt_ff <= 36'h0;
    else if (ce)
    begin
      if (!out_en_ff || per_hit)
        per_cnt_ff <= 36'h0;
      else if (mode_ff == MODE_EVERY_SEC || mode_ff == MODE_EVERY_MIN)
        per_cnt_ff <= per_cnt_ff + 36'h1;
    end
  end
  assign per_hit = out_en_ff && !eng_busy &&
                   ((mode_ff == MODE_EVERY_SEC && per_cnt_ff >= 36'(SEC_CYCLES - 1)) ||
                    (mode_ff == MODE_EVERY_MIN &&
                     per_cnt_ff >= 36'(SEC_CYCLES) * 36'h3C - 36'h1));

  // Tuning requests
  assign req = (init_ff == RUNNING) && !eng_busy &&
               ((ramp_rise && tune_on && !(once_ff && tuned_once_ff)) ||
                per_hit || trig_ff);

  // ==========================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff   <= tune_mode_e'(`MODE_RST);
      gain_ff   <= `GAIN_RST;
      out_en_ff <= 1'b0;
      once_ff   <= 1'b0;
      trig_ff   <= 1'b0;
    end
    else if (ce)
    begin
      trig_ff <= 1'b0;
      if (wr_acc && paddr == `OFS_CTRL)
      begin
        out_en_ff <= pwdata[`CTRL_OUT_EN];
        once_ff   <= pwdata[`CTRL_ONCE_ONLY];
      end
      else if (wr_acc && paddr == `OFS_MODE)
        mode_ff <= nxt_mode;
      else if (wr_acc && paddr == `OFS_GAIN)
      begin
        if (pwdata[6:0] < `GAIN_MIN)
          gain_ff <= `GAIN_MIN;
        else if (pwdata[6:0] > `GAIN_MAX)
          gain_ff <= `GAIN_MAX;
        else
          gain_ff <= pwdata[6:0];
      end
      else if (wr_acc && paddr == `OFS_TRIG)
        trig_ff <= pwdata[0];
    end
  end

  // ==========================================================
  // Active coefficient RAM
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_ff       <= INIT_READ;
      ram_ff        <= '{a: `SAFE_A, b: `SAFE_B, c: `SAFE_C};
      tuned_once_ff <= 1'b0;
    end
    else if (ce)
    begin
      case (init_ff)
        INIT_READ: init_ff <= INIT_LOAD;
        INIT_LOAD:
        begin
          init_ff <= RUNNING;
          if (tune_on)
            ram_ff <= '{a: `SAFE_A, b: `SAFE_B, c: `SAFE_C};
          else
            ram_ff <= user_rd;
        end
        default:
        begin
          if (wr_acc && paddr == `OFS_MODE && !tune_on && nxt_mode != MODE_OFF)
            ram_ff <= '{a: `SAFE_A, b: `SAFE_B, c: `SAFE_C};
          else if (wr_acc && paddr == `OFS_MODE && tune_on && nxt_mode == MODE_OFF)
            ram_ff <= user_rd;
          else if (tune_done && tune_on)
          begin
            ram_ff        <= tune_res;
            tuned_once_ff <= 1'b1;
          end
          else if (wr_acc && paddr == `OFS_COEF_A)
            ram_ff.a <= pwdata[15:0];
          else if (wr_acc && paddr == `OFS_COEF_B)
            ram_ff.b <= pwdata[15:0];
          else if (wr_acc && paddr == `OFS_COEF_C)
            ram_ff.c <= pwdata[15:0];
        end
      endcase
    end
  end

  // Store request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      store_wr_ff <= 1'b0;
    else if (ce)
      store_wr_ff <= wr_acc && paddr == `OFS_STORE && pwdata[0];
  end

  coef_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr      (store_wr_ff),
    .wdata   (ram_ff),
    .rdata   (user_rd)
  );

  tune_engine #(.RUN_CYCLES(RUN_CYCLES)) u_tune (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (req),
    .gain    (gain_ff),
    .base    (ram_ff),
    .busy    (eng_busy),
    .done    (tune_done),
    .result  (tune_res)
  );

  // ==========================================================
  // Outputs to loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_coef <= '{a: `SAFE_A, b: `SAFE_B, c: `SAFE_C};
      tune_busy <= 1'b0;
    end
    else if (ce)
    begin
      loop_coef <= ram_ff;
      tune_busy <= eng_busy;
    end
  end

  // ==========================================================
  // APB read and answer
  always_comb
  begin
    mapped = 1'b1;
    if (paddr == `OFS_CTRL || paddr == `OFS_MODE || paddr == `OFS_GAIN)
      mapped = 1'b1;
    else if (paddr == `OFS_TRIG || paddr == `OFS_STORE || paddr == `OFS_STATUS)
      mapped = 1'b1;
    else if (paddr == `OFS_COEF_A || paddr == `OFS_COEF_B || paddr == `OFS_COEF_C)
      mapped = 1'b1;
    else if (paddr == `OFS_TUNE_A || paddr == `OFS_TUNE_B || paddr == `OFS_TUNE_C)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == `OFS_CTRL)
          prdata <= {30'h0, once_ff, out_en_ff};
        else if (paddr == `OFS_MODE)
          prdata <= {30'h0, mode_ff};
        else if (paddr == `OFS_GAIN)
          prdata <= {25'h0, gain_ff};
        else if (paddr == `OFS_COEF_A)
          prdata <= {16'h0, ram_ff.a};
        else if (paddr == `OFS_COEF_B)
          prdata <= {16'h0, ram_ff.b};
        else if (paddr == `OFS_COEF_C)
          prdata <= {16'h0, ram_ff.c};
        else if (paddr == `OFS_STATUS)
          prdata <= {28'h0, init_ff == RUNNING, tuned_once_ff, ramp_d_ff, eng_busy};
        else if (paddr == `OFS_TUNE_A)
          prdata <= {16'h0, tune_res.a};
        else if (paddr == `OFS_TUNE_B)
          prdata <= {16'h0, tune_res.b};
        else if (paddr == `OFS_TUNE_C)
          prdata <= {16'h0, tune_res.c};
      end
    end
  end

  // ==========================================================
  // Checks
  tune_install_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && init_ff == RUNNING && tune_done && tune_on && !wr_acc |=> ram_ff == $past(tune_res))
    else $error("tuned set not installed");
  init_safe_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && init_ff == INIT_LOAD && tune_on |=> ram_ff == {`SAFE_A, `SAFE_B, `SAFE_C})
    else $error("safe set not loaded at power-up");
  init_user_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && init_ff == INIT_LOAD && !tune_on |=> ram_ff == $past(user_rd))
    else $error("user set not loaded at power-up");
  gain_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    gain_ff >= `GAIN_MIN && gain_ff <= `GAIN_MAX)
    else $error("gain out of range");
  loop_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 ce |-> loop_coef == $past(ram_ff))
    else $error("loop coefficients stale");
  trig_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && req ##1 ce |-> eng_busy)
    else $error("trigger did not start run");
  store_save_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && store_wr_ff ##1 ce ##1 ce |-> user_rd == $past(ram_ff, 2))
    else $error("store did not save active set");
endmodule

//--- tb/pmbus_host_model.sv
// Host side bus master model for the loop compensation block
`timescale 1ns/100ps
module pmbus_host_model
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================
  // One transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- tb/adaptive_loop_comp_ctrl_tb.sv
// Self-checking testbench for the loop compensation control block
`timescale 1ns/100ps
`include "loop_comp_map.svh"
module adaptive_loop_comp_ctrl_tb;
  import loop_comp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        ramp_done;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  coef_set_s   loop_coef;
  logic        tune_busy;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  adaptive_loop_comp_ctrl #(.RUN_CYCLES(20), .SEC_CYCLES(50)) dut
  (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ramp_done(ramp_done),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_coef(loop_coef),
    .tune_busy(tune_busy)
  );

  pmbus_host_model host
  (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ==========================================================
  // Helpers
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
    cmp({47'h0, e}, 48'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    cmp({15'h0, e, q}, {15'h0, xe, x});
  endtask

  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (tune_busy !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    cmp({47'h0, tune_busy}, {47'h0, v});
  endtask

  task automatic coef(input logic [47:0] x);
    repeat (3) @(posedge pclk);
    cmp(loop_coef, x);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_init();
    repeat (4) @(posedge pclk);
    rd(`OFS_STATUS, 32'h0000_0008, 1'b0);
    rd(`OFS_MODE, 32'h0000_0001, 1'b0);
    rd(`OFS_GAIN, 32'h0000_0032, 1'b0);
    rd(12'h030, 32'h0000_0000, 1'b1);
    cmp(loop_coef, {`SAFE_A, `SAFE_B, `SAFE_C});
  endtask

  task automatic t_ramp();
    wr(`OFS_GAIN, 32'h0000_0005);
    rd(`OFS_GAIN, 32'h0000_000A, 1'b0);
    wr(`OFS_GAIN, 32'h0000_0064);
    wr(`OFS_CTRL, 32'h0000_0001);
    ramp_done <= 1'b1;
    wait_busy(1'b1, 10);
    wr(`OFS_TRIG, 32'h0000_0001);
    wait_busy(1'b0, 40);
    repeat (3) @(posedge pclk);
    cmp({47'h0, tune_busy}, 48'h0);
    coef({16'h2000, 16'hC000, 16'h2000});
  endtask

  task automatic t_manual();
    wr(`OFS_TRIG, 32'h0000_0001);
    wait_busy(1'b1, 10);
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    cmp({47'h0, tune_busy}, 48'h1);
    ce <= 1'b1;
    wait_busy(1'b0, 40);
    coef({16'h4000, 16'h8000, 16'h4000});
  endtask

  task automatic t_once();
    wait_busy(1'b0, 40);
    wr(`OFS_MODE, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0003);
    ramp_done <= 1'b0;
    repeat (8) @(posedge pclk);
    ramp_done <= 1'b1;
    repeat (12) @(posedge pclk);
    cmp({47'h0, tune_busy}, 48'h0);
    wr(`OFS_CTRL, 32'h0000_0001);
    ramp_done <= 1'b0;
    repeat (8) @(posedge pclk);
    ramp_done <= 1'b1;
    wait_busy(1'b1, 12);
    wait_busy(1'b0, 40);
  endtask

  task automatic t_switch();
    wr(`OFS_MODE, 32'h0000_0000);
    coef({`USER_RST_A, `USER_RST_B, `USER_RST_C});
    wr(`OFS_COEF_A, 32'h0000_1234);
    coef({16'h1234, `USER_RST_B, `USER_RST_C});
    wr(`OFS_MODE, 32'h0000_0001);
    coef({`SAFE_A, `SAFE_B, `SAFE_C});
    wr(`OFS_STORE, 32'h0000_0001);
    wr(`OFS_MODE, 32'h0000_0000);
    coef({`SAFE_A, `SAFE_B, `SAFE_C});
  endtask

  task automatic t_periodic();
    wr(`OFS_MODE, 32'h0000_0002);
    wait_busy(1'b1, 120);
    wait_busy(1'b0, 40);
    wr(`OFS_MODE, 32'h0000_0003);
    wait_busy(1'b0, 40);
    wait_busy(1'b1, 3100);
  endtask

  initial
  begin
    presetn = 1'b0;
    ramp_done = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_init();
    t_ramp();
    t_manual();
    t_switch();
    t_periodic();
    t_once();
    tally_and_finish();
  end
endmodule
